// file: logic/bcrb_pkg.sv
/*
 Package for the buck control register bank: register indices, field
 positions, reset values and carrier structs.
 Assumes a 16-bit register word reached by an external serial-port engine.
*/
`default_nettype none
package bcrb_pkg;

   // ----------------------------------------------------------------
   // Register indices (8-bit register address space)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONV1_CTRL     = 8'h2a;
   localparam logic [7:0] ADDR_CONV1_CTRL_INV = 8'h2b;
   localparam logic [7:0] ADDR_CONV2_CTRL     = 8'h2c;
   localparam logic [7:0] ADDR_CONV2_CTRL_INV = 8'h2d;
   localparam logic [7:0] ADDR_STATE_REQ_INV  = 8'h25;
   localparam logic [7:0] ADDR_STATE_READOUT  = 8'h26;
   localparam logic [7:0] ADDR_ID_PRIMARY     = 8'h27;
   localparam logic [7:0] ADDR_ID_SECONDARY   = 8'h28;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EN_POS       = 2;
   localparam int MODE_LSB     = 0;
   localparam int NORMAL_POS   = 0;
   localparam int INIT_RUN_POS = 1;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] STATE_REQ_INV_RST = 16'h0003;
   localparam logic [15:0] STATE_READOUT_RST = 16'h0000;
   localparam logic [15:0] ID2_VALUE         = 16'h0000;
   // Arbitrary identity values, not tied to any real part
   localparam logic [3:0]  FAMILY_CODE_DEF   = 4'h1;
   localparam logic [3:0]  PART_CODE_DEF     = 4'h2;
   localparam logic [2:0]  SIL_REV_DEF       = 3'h0;

   // ----------------------------------------------------------------
   // Operating mode codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_PFM = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h3;

   // Register-port request from the serial-port engine
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } bcrb_req_t;

   // Converter settings as applied to one switcher
   typedef struct packed {
      logic       enable;
      logic       pwm;
      logic [1:0] mode;
   } bcrb_conv_t;

   // Primary/inverse pair of one converter control register
   typedef struct packed {
      logic       en;
      logic [1:0] mode;
      logic       en_inv;
      logic [1:0] mode_inv;
   } bcrb_pair_t;

endpackage
`default_nettype wire

// file: logic/bcrb_conv_apply.sv
/*
 One converter's complement check: applies each field (enable, mode) of a
 primary/inverse pair to the switcher only while that field agrees, otherwise holds that field's last good setting.
 Assumes the enable pin is already synchronised.
*/
`default_nettype none
module bcrb_conv_apply
   import bcrb_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire bcrb_pair_t pair,
   input  wire logic       pin_en,
   input  wire logic       en_rst,
   input  wire logic [1:0] mode_rst,
   output var  bcrb_conv_t applied
);
   import bcrb_pkg::*;

   typedef struct packed {
      logic       en;
      logic [1:0] mode;
      bcrb_conv_t out;
   } bcrb_ca_state_t;

   bcrb_ca_state_t st_r;
   bcrb_ca_state_t st_nxt;
   logic           loaded_r;

   always_comb begin
      st_nxt = st_r;
      if (!loaded_r) begin
         st_nxt.en   = en_rst;
         st_nxt.mode = mode_rst;
      end else begin
         if (pair.en == ~pair.en_inv)                // see [R1] [R5] [R13]
            st_nxt.en = pair.en;
         if (pair.mode == ~pair.mode_inv)            // see [R3] [R7] [R13]
            st_nxt.mode = pair.mode;
      end
      st_nxt.out.enable = st_nxt.en & pin_en;        // see [R2] [R6]
      st_nxt.out.mode   = st_nxt.mode;
      st_nxt.out.pwm    = (st_nxt.mode == MODE_PWM); // see [R4] [R8]
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r     <= '0;
         loaded_r <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         loaded_r <= 1'b1;
      end
   end

   assign applied = st_r.out;
endmodule
`default_nettype wire

// file: logic/bcrb_top.sv
/*
 Buck control register bank: converter control pairs, state request,
 state readout and identification registers on a 16-bit register port.
 Assumes a serial-port engine on core_clk that presents one-cycle read and
 write strobes, and that nrst is the power-on reset.
*/
`default_nettype none

// What this block does
// [R1] Converter one enable applied only when it equals inverse of its shadow.
// [R2] Converter one on needs enable one and its enable pin high.
// [R3] Converter one mode applied only when equal to inverse shadow field.
// [R4] Converter one mode 00 is PFM, 11 is PWM, others reserved.
// [R5] Converter two enable applied only when equal to inverse shadow.
// [R6] Converter two on needs enable one and its enable pin high.
// [R7] Converter two mode applied only when equal to inverse shadow.
// [R8] Converter two mode 00 is PFM, 11 is PWM, others reserved.
// [R9] Converter fields return to defaults only on power-on reset.
// [R11] Self-updating bits are host read-write and hardware may change them.
// [R12] OTP-loaded bits take their default from OTP storage.
// [R13] On mismatch the switcher keeps its last checked setting.
// [R14] Host writes primary and inverse registers with complementary values.
module bcrb_top
   import bcrb_pkg::*;
#(
   parameter int DATA_W = 16
)
(
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire bcrb_req_t         req,
   output var  logic [DATA_W-1:0] rdata,
   output var  logic              rvalid,
   output var  logic              addr_err,
   input  wire logic              otp_valid,
   input  wire logic              otp_conv1_en,
   input  wire logic [1:0]        otp_conv1_mode,
   input  wire logic              otp_conv2_en,
   input  wire logic [1:0]        otp_conv2_mode,
   input  wire logic [4:0]        controller_state_code,
   input  wire logic              normal_done,
   input  wire logic              init_run_done,
   input  wire logic              converter_one_enable_pin,
   input  wire logic              converter_two_enable_pin,
   output var  bcrb_conv_t        converter_one,
   output var  bcrb_conv_t        converter_two,
   output var  logic              normal_request,
   output var  logic              init_run_request
);
   import bcrb_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      bcrb_pair_t        c1;
      bcrb_pair_t        c2;
      logic [1:0]        req_inv;
      logic              otp_done;
      logic [DATA_W-1:0] rdata;
      logic              rvalid;
      logic              addr_err;
   } bcrb_state_t;

   bcrb_state_t st_r;
   bcrb_state_t st_nxt;

   logic [2:0] pin1_sync_r;
   logic [2:0] pin2_sync_r;
   logic       pin1_r;
   logic       pin2_r;

   bcrb_conv_t conv1_app;
   bcrb_conv_t conv2_app;

   // Packs one register half of a pair into a 16-bit word
   function automatic logic [DATA_W-1:0] pack_ctrl(input logic en,
                                                   input logic [1:0] md);
      logic [DATA_W-1:0] w;
      w = '0;
      w[EN_POS] = en;
      w[MODE_LSB +: 2] = md;
      return w;
   endfunction

   // ----------------------------------------------------------------
   // Enable pin synchronisers
   // ----------------------------------------------------------------
   // Change is accepted only when stages two and three agree
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pin1_sync_r <= 3'h0;
         pin2_sync_r <= 3'h0;
         pin1_r      <= 1'b0;
         pin2_r      <= 1'b0;
      end else begin
         pin1_sync_r <= {pin1_sync_r[1:0], converter_one_enable_pin};
         pin2_sync_r <= {pin2_sync_r[1:0], converter_two_enable_pin};
         if (pin1_sync_r[1] == pin1_sync_r[2])
            pin1_r <= pin1_sync_r[2];
         if (pin2_sync_r[1] == pin2_sync_r[2])
            pin2_r <= pin2_sync_r[2];
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt          = st_r;
      st_nxt.rvalid   = 1'b0;
      st_nxt.addr_err = 1'b0;

      // Defaults come from OTP once it is valid, not from constants
      if (!st_r.otp_done && otp_valid) begin                 // see [R12]
         st_nxt.otp_done    = 1'b1;
         st_nxt.c1.en       = otp_conv1_en;
         st_nxt.c1.mode     = otp_conv1_mode;
         st_nxt.c1.en_inv   = ~otp_conv1_en;
         st_nxt.c1.mode_inv = ~otp_conv1_mode;
         st_nxt.c2.en       = otp_conv2_en;
         st_nxt.c2.mode     = otp_conv2_mode;
         st_nxt.c2.en_inv   = ~otp_conv2_en;
         st_nxt.c2.mode_inv = ~otp_conv2_mode;
      end

      // Controller completes a request: self-update of the request bits
      if (normal_done)                                       // see [R11]
         st_nxt.req_inv[NORMAL_POS] = 1'b1;
      if (init_run_done)
         st_nxt.req_inv[INIT_RUN_POS] = 1'b1;

      if (req.wr) begin
         unique case (req.addr)
            ADDR_CONV1_CTRL: begin
               st_nxt.c1.en   = req.wdata[EN_POS];
               st_nxt.c1.mode = req.wdata[MODE_LSB +: 2];
            end
            ADDR_CONV1_CTRL_INV: begin
               st_nxt.c1.en_inv   = req.wdata[EN_POS];
               st_nxt.c1.mode_inv = req.wdata[MODE_LSB +: 2];
            end
            ADDR_CONV2_CTRL: begin
               st_nxt.c2.en   = req.wdata[EN_POS];
               st_nxt.c2.mode = req.wdata[MODE_LSB +: 2];
            end
            ADDR_CONV2_CTRL_INV: begin
               st_nxt.c2.en_inv   = req.wdata[EN_POS];
               st_nxt.c2.mode_inv = req.wdata[MODE_LSB +: 2];
            end
            ADDR_STATE_REQ_INV: begin
               // Host write lands after the self-update, so host wins
               st_nxt.req_inv[NORMAL_POS] = req.wdata[NORMAL_POS];
               st_nxt.req_inv[INIT_RUN_POS] = req.wdata[INIT_RUN_POS];
            end
            ADDR_STATE_READOUT, ADDR_ID_PRIMARY, ADDR_ID_SECONDARY: begin
            end
            default: st_nxt.addr_err = 1'b1;
         endcase
      end

      if (req.rd) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = '0;
         unique case (req.addr)
            ADDR_CONV1_CTRL:
               st_nxt.rdata = pack_ctrl(st_r.c1.en, st_r.c1.mode);
            ADDR_CONV1_CTRL_INV:
               st_nxt.rdata = pack_ctrl(st_r.c1.en_inv, st_r.c1.mode_inv);
            ADDR_CONV2_CTRL:
               st_nxt.rdata = pack_ctrl(st_r.c2.en, st_r.c2.mode);
            ADDR_CONV2_CTRL_INV:
               st_nxt.rdata = pack_ctrl(st_r.c2.en_inv, st_r.c2.mode_inv);
            ADDR_STATE_REQ_INV:
               st_nxt.rdata[1:0] = st_r.req_inv;
            ADDR_STATE_READOUT:
               st_nxt.rdata[4:0] = controller_state_code;
            ADDR_ID_PRIMARY:
               st_nxt.rdata = {2'h0, SIL_REV_DEF, 3'h0,
                               FAMILY_CODE_DEF, PART_CODE_DEF};
            ADDR_ID_SECONDARY:
               st_nxt.rdata = ID2_VALUE;
            default: st_nxt.addr_err = 1'b1;
         endcase
      end
   end

   // Only power-on reset restores converter defaults; no soft reset path
   always_ff @(posedge core_clk or negedge nrst) begin        // see [R9]
      if (!nrst) begin
         st_r         <= '0;
         st_r.c1.en_inv   <= 1'b1;
         st_r.c1.mode_inv <= 2'h3;
         st_r.c2.en_inv   <= 1'b1;
         st_r.c2.mode_inv <= 2'h3;
         st_r.req_inv <= STATE_REQ_INV_RST[1:0];
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Converter application
   // ----------------------------------------------------------------
   bcrb_conv_apply u_conv1 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pair     (st_r.c1),
      .pin_en   (pin1_r),
      .en_rst   (1'b0),
      .mode_rst (MODE_PFM),
      .applied  (conv1_app)
   );

   bcrb_conv_apply u_conv2 (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pair     (st_r.c2),
      .pin_en   (pin2_r),
      .en_rst   (1'b0),
      .mode_rst (MODE_PFM),
      .applied  (conv2_app)
   );

   assign converter_one    = conv1_app;
   assign converter_two    = conv2_app;
   assign rdata            = st_r.rdata;
   assign rvalid           = st_r.rvalid;
   assign addr_err         = st_r.addr_err;
   assign normal_request   = ~st_r.req_inv[NORMAL_POS];
   assign init_run_request = ~st_r.req_inv[INIT_RUN_POS];
endmodule
`default_nettype wire

// file: sim/bcrb_monitor.sv
/* Port checker for bcrb_top.
   Assumes a bind onto bcrb_top and the single core_clk domain. */
`default_nettype none
module bcrb_monitor (
   input wire logic                 core_clk,
   input wire logic                 nrst,
   input wire bcrb_pkg::bcrb_req_t  req,
   input wire logic [15:0]          rdata,
   input wire logic                 rvalid,
   input wire logic                 addr_err,
   input wire logic                 otp_valid,
   input wire logic [4:0]           controller_state_code,
   input wire logic                 normal_done,
   input wire logic                 converter_one_enable_pin,
   input wire logic                 converter_two_enable_pin,
   input wire bcrb_pkg::bcrb_conv_t converter_one,
   input wire bcrb_pkg::bcrb_conv_t converter_two,
   input wire logic                 normal_request
);
   import bcrb_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   logic mapped;
   assign mapped = req.addr inside {[8'h25:8'h28], [8'h2a:8'h2d]};
   chk_read_answer: assert property (
      req.rd && mapped |=> rvalid && !addr_err) else $error("read lost");
   chk_unmapped_err: assert property (
      (req.rd || req.wr) && !mapped |=> addr_err) else $error("no addr_err");
   chk_id_value: assert property (
      req.rd && req.addr == ADDR_ID_PRIMARY |=> rdata == {5'h0, SIL_REV_DEF,
      FAMILY_CODE_DEF, PART_CODE_DEF}) else $error("bad id");
   chk_state_value: assert property (
      req.rd && req.addr == ADDR_STATE_READOUT |=>
      rdata == {11'h0, $past(controller_state_code)}) else $error("bad state");
   chk_pwm_code: assert property (
      converter_one.pwm == (converter_one.mode == MODE_PWM) &&
      converter_two.pwm == (converter_two.mode == MODE_PWM))
      else $error("pwm flag wrong");
   chk_one_pin_off: assert property (
      !converter_one_enable_pin [*8] |=> !converter_one.enable)
      else $error("one on without pin");
   chk_two_pin_off: assert property (
      !converter_two_enable_pin [*8] |=> !converter_two.enable)
      else $error("two on without pin");
   chk_mode_hold: assert property (
      (!req.wr && !$rose(otp_valid)) [*4] |=> $stable(converter_one.mode)
      && $stable(converter_two.mode)) else $error("mode moved");
   chk_req_write: assert property (
      req.wr && req.addr == ADDR_STATE_REQ_INV && !req.wdata[NORMAL_POS]
      |-> ##[1:2] normal_request) else $error("request not raised");
   chk_done_clears: assert property (
      normal_done && !req.wr |-> ##[1:2] !normal_request)
      else $error("request not dropped");
endmodule
`default_nettype wire

// file: sim/bcrb_host.sv
/* Host model: one register access per access call, two per wr_pair call, on the request port.
   Assumes the bank answers one cycle after the strobe edge. */
`default_nettype none
module bcrb_host (
   input  wire logic                core_clk,
   input  wire logic [15:0]         rdata,
   input  wire logic                addr_err,
   output var  bcrb_pkg::bcrb_req_t req
);
   import bcrb_pkg::*;
   initial req = '0;
   task automatic access(input logic w, input logic [7:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic e);
      @(posedge core_clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge core_clk);
      // Idle lines carry the inverse, never a stale copy
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1;
      q = rdata;
      e = addr_err;
   endtask
   task automatic wr_pair(input logic [7:0] a, input logic [2:0] v,
      input logic [2:0] vi);
      logic [15:0] q;
      logic        e;
      access(1'b1, a, {13'h0, v}, q, e);
      access(1'b1, a + 8'h1, {13'h0, vi}, q, e);
   endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
/* Bench for bcrb_top: host model, port checker, reference model.
   Assumes bcrb_pkg and the design files are compiled first. */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bcrb_pkg::*;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   bcrb_req_t   req;
   logic [15:0] rdata, q;
   logic        rvalid, addr_err, e, otp_valid, otp_conv1_en, otp_conv2_en;
   logic [1:0]  otp_conv1_mode, otp_conv2_mode;
   logic [4:0]  controller_state_code;
   logic        normal_done, init_run_done, normal_request, init_run_request;
   logic        converter_one_enable_pin, converter_two_enable_pin;
   bcrb_conv_t  converter_one, converter_two;
   logic [2:0]  v, vi, app [2];
   logic [7:0]  x, y;
   logic [31:0] seed = 32'hd71bb16b, r;
   int          bad_count = 0, checks_done = 0, cycles = 0, c;
   bcrb_top dut (.core_clk, .nrst, .req, .rdata, .rvalid, .addr_err,
      .otp_valid, .otp_conv1_en, .otp_conv1_mode, .otp_conv2_en,
      .otp_conv2_mode, .controller_state_code, .normal_done,
      .init_run_done, .converter_one_enable_pin, .converter_two_enable_pin,
      .converter_one, .converter_two, .normal_request, .init_run_request);
   bcrb_host host (.core_clk, .rdata, .addr_err, .req);
   always #5 core_clk = ~core_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] exp_conv(logic [2:0] a, logic pin);
      return {a[2] & pin, a[1:0] == MODE_PWM, a[1:0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Whole run is under a thousand cycles; this only cuts a hang
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      {otp_valid, otp_conv1_en, otp_conv1_mode, otp_conv2_en, otp_conv2_mode,
         controller_state_code, normal_done, init_run_done,
         converter_one_enable_pin, converter_two_enable_pin} = '0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      #1;
      check({8'h0, converter_one, converter_two}, 16'h0);
      host.access(1'b0, ADDR_STATE_REQ_INV, 16'h0, q, e);
      check(q, STATE_REQ_INV_RST);
      for (int i = 0; i < 2; i++) begin
         host.access(i[0], 8'h29 + 8'(i * 7), 16'h0, q, e);
         check({15'h0, e}, 16'h1);
      end
      $display("test reset and map done");
      r = rnd();
      @(posedge core_clk);
      {otp_conv1_en, otp_conv1_mode, otp_conv2_en, otp_conv2_mode} <= r[5:0];
      otp_valid <= 1'b1;
      controller_state_code <= r[12:8];
      repeat (3) @(posedge core_clk);
      host.access(1'b0, ADDR_CONV1_CTRL, 16'h0, q, e);
      check(q & 16'h7, {13'h0, r[5:3]});
      host.access(1'b0, ADDR_CONV2_CTRL, 16'h0, q, e);
      check(q & 16'h7, {13'h0, r[2:0]});
      for (int i = 0; i < 3; i++) begin
         host.access(1'b1, ADDR_STATE_READOUT + 8'(i), 16'hffff, q, e);
         check({15'h0, e}, 16'h0);
         host.access(1'b0, ADDR_STATE_READOUT + 8'(i), 16'h0, q, e);
         check(q, i == 0 ? {11'h0, r[12:8]} : i == 1 ? {5'h0, SIL_REV_DEF,
            FAMILY_CODE_DEF, PART_CODE_DEF} : ID2_VALUE);
      end
      host.access(1'b1, ADDR_STATE_REQ_INV, 16'h0, q, e);
      repeat (2) @(posedge core_clk);
      #1;
      check({14'h0, normal_request, init_run_request}, 16'h3);
      for (int i = 0; i < 2; i++) begin
         @(posedge core_clk);
         {normal_done, init_run_done} <= 2'b10 >> i;
         @(posedge core_clk);
         {normal_done, init_run_done} <= 2'b00;
         host.access(1'b0, ADDR_STATE_REQ_INV, 16'h0, q, e);
         check(q, 16'(i * 2 + 1));
      end
      $display("test otp, readout and requests done");
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         c = (i < 2) ? i : int'(r[0]);
         v = r[3:1];
         vi = (i < 2 || r[4]) ? ~v : r[7:5];
         @(posedge core_clk);
         {converter_one_enable_pin, converter_two_enable_pin} <= r[9:8];
         host.wr_pair(c ? ADDR_CONV2_CTRL : ADDR_CONV1_CTRL, v, vi);
         if (v[2] == ~vi[2]) app[c][2] = v[2];
         if (v[1:0] == ~vi[1:0]) app[c][1:0] = v[1:0];
         repeat (8) @(posedge core_clk);
         #1;
         x = {converter_one, converter_two};
         y = {exp_conv(app[0], r[9]), exp_conv(app[1], r[8])};
         if (i > 0) check({8'h0, x}, {8'h0, y});
      end
      $display("test converters done");
      print_verdict();
   end
endmodule
bind bcrb_top bcrb_monitor mon (.core_clk, .nrst, .req, .rdata, .rvalid,
   .addr_err, .otp_valid, .controller_state_code, .normal_done,
   .converter_one_enable_pin, .converter_two_enable_pin, .converter_one,
   .converter_two, .normal_request);
`default_nettype wire
